// *** rtl/ulsl_line_status.sv ***
// Line status logic of the serial transceiver with its APB register slave
// How it works
// - Bit 7 set when a character with parity, framing or break error is queued.
// - Reading the line status register clears bit 7.
// - Bit 6 high when holding and shift register are both empty.
// - In queued mode bit 6 needs an empty queue and empty shift register.
// - Single mode: bit 5 sets when the character moves into the shift register.
// - Bit 5 clears together with the host's write of a character.
// - With its enable set, an empty holding register raises the interrupt.
// - Queued mode: bit 5 set on empty queue, cleared after one byte written.
// - Bit 4 reports a break: line low for a full character frame.
// - Only one break character is queued per break, however long it lasts.
// - Reset leaves error summary, break and framing bits at zero.
// - Framing error bit belongs to the character at the queue head.
// - Bit 0 set while received characters wait, cleared when none remain.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ulsl_line_status
	import ulsl_pkg::*;
(
	input  wire logic             CLOCK_I,        // System clock, 10 MHz
	input  wire logic             SYS_RST_I,      // Async reset, active high
	input  wire logic             PSEL_I,         // APB select
	input  wire logic             PENABLE_I,      // APB access phase
	input  wire logic             PWRITE_I,       // APB direction
	input  wire logic [11:0]      PADDR_I,        // APB byte address
	input  wire logic [31:0]      PWDATA_I,       // APB write data
	output logic      [31:0]      PRDATA_O,       // APB read data
	output logic                  PREADY_O,       // APB ready
	output logic                  PSLVERR_O,      // APB error, unmapped
	output logic                  TX_LOAD_O,      // Character written, pulse
	output logic      [7:0]       TX_BYTE_O,      // Character for the engine
	input  wire logic             TX_TAKE_I,      // Character into shift reg
	input  wire logic             TX_SHIFT_BUSY_I,// Shift register holds data
	input  wire logic             RX_PUSH_I,      // Received character pulse
	input  wire ulsl_rxflags_type RX_FLAGS_I,     // Its error flags
	input  wire logic             RX_POP_I,       // Head character read out
	input  wire logic             RX_FRAME_LOW_I, // Line low for one frame
	input  wire logic             RX_LINE_I,      // Receive line level
	output logic                  THR_IRQ_O       // Holding empty interrupt
);

	// ==========================================================
	// Address decode
	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction

	logic                   pready_q;
	logic                   slverr_q;
	logic [31:0]            prdata_q;
	logic [1:0]             ctrl_q;
	logic [1:0]             ctrl_d;
	logic [6:0]             tx_cnt_q;
	logic [6:0]             tx_cnt_d;
	logic                   irq_q;
	logic                   load_q;
	logic [7:0]             byte_q;
	logic [6:0]             rx_cnt_q;
	logic [ULSL_PTR_W-1:0]  wr_ptr_q;
	logic [ULSL_PTR_W-1:0]  rd_ptr_q;
	ulsl_rxflags_type       flag_mem_q [64];
	ulsl_rxflags_type       head;
	ulsl_rxflags_type       pf;
	logic                   err_q;
	logic                   oe_q;
	logic                   brk_arm_q;
	ulsl_lsr_type           line_status;
	logic                   acc_done;
	logic                   unmapped;
	logic                   rd_clr;
	logic                   wr_tx;
	logic                   fifo_mode;
	logic [6:0]             cap;
	logic                   accept;
	logic                   take;
	logic                   brk_push;
	logic                   push;
	logic                   pop;
	logic                   store;
	logic                   err_set;
	logic                   ovr_set;

	// ==========================================================
	// Bus strobes; a write or read side effect lands at the ready edge
	assign acc_done  = PSEL_I & PENABLE_I & pready_q;
	assign unmapped  = ~(hit(PADDR_I, ULSL_OFS_STATUS) | hit(PADDR_I, ULSL_OFS_CTRL)
	                   | hit(PADDR_I, ULSL_OFS_TXDATA));
	assign rd_clr    = acc_done & ~PWRITE_I & hit(PADDR_I, ULSL_OFS_STATUS);
	assign wr_tx     = acc_done & PWRITE_I & hit(PADDR_I, ULSL_OFS_TXDATA);
	assign fifo_mode = ctrl_q[ULSL_CTRL_FIFO_BIT];
	assign cap       = fifo_mode ? ULSL_DEPTH : ULSL_SINGLE;

	// Next control value, used early so the interrupt drops at once
	always_comb begin
		ctrl_d = ctrl_q;
		if (acc_done & PWRITE_I & hit(PADDR_I, ULSL_OFS_CTRL)) begin
			ctrl_d = PWDATA_I[1:0];
		end
	end

	// ==========================================================
	// Transmit occupancy; a write beyond capacity is dropped
	assign accept = wr_tx & (tx_cnt_q < cap);
	assign take   = TX_TAKE_I & (tx_cnt_q != 7'h00);
	always_comb begin
		tx_cnt_d = tx_cnt_q;
		if (accept & ~take) begin
			tx_cnt_d = tx_cnt_q + 7'h01;
		end else if (take & ~accept) begin
			tx_cnt_d = tx_cnt_q - 7'h01;
		end
	end

	// ==========================================================
	// Receive queue control
	// one break per condition
	assign brk_push = RX_FRAME_LOW_I & ~brk_arm_q;
	assign push     = RX_PUSH_I | brk_push;
	assign pop      = RX_POP_I & (rx_cnt_q != 7'h00);
	// Overrun keeps the queued data intact, new character is lost
	assign store    = push & ((rx_cnt_q < cap) | pop);
	assign ovr_set  = push & ~store;
	assign err_set  = store & (pf.bi | pf.fe | pf.pe);
	assign head     = flag_mem_q[rd_ptr_q];

	// Break character carries the break flag on top of the receiver's own
	always_comb begin
		pf    = RX_FLAGS_I;
		pf.bi = RX_FLAGS_I.bi | brk_push;
	end

	// ==========================================================
	// Status byte assembled from the block's state
	always_comb begin
		line_status      = '0;
		line_status.err  = err_q;
		line_status.temt = (tx_cnt_q == 7'h00) & ~TX_SHIFT_BUSY_I;
		line_status.thre = (tx_cnt_q == 7'h00);
		line_status.bi   = (rx_cnt_q != 7'h00) & head.bi;
		line_status.fe   = (rx_cnt_q != 7'h00) & head.fe;
		line_status.pe   = (rx_cnt_q != 7'h00) & head.pe;
		line_status.oe   = oe_q;
		line_status.dr   = (rx_cnt_q != 7'h00);
	end

	// ==========================================================
	// APB slave: one wait state, data and error captured before ready
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pready_q <= 1'b0;
			slverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= PSEL_I & PENABLE_I & ~pready_q;
			if (PSEL_I & PENABLE_I & ~pready_q) begin
				slverr_q <= unmapped;
				prdata_q <= 32'h0000_0000;
				if (~PWRITE_I & hit(PADDR_I, ULSL_OFS_STATUS)) begin
					prdata_q <= {24'h00_0000, line_status};
				end else if (~PWRITE_I & hit(PADDR_I, ULSL_OFS_CTRL)) begin
					prdata_q <= {30'h0000_0000, ctrl_q};
				end
			end
		end
	end

	// Control register
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ctrl_q <= ULSL_CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Transmit side: count, character hand-off and interrupt
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			tx_cnt_q <= 7'h00;
			load_q   <= 1'b0;
			byte_q   <= 8'h00;
			irq_q    <= 1'b0;
		end else begin
			tx_cnt_q <= tx_cnt_d;
			load_q   <= accept;
			if (accept) begin
				byte_q <= PWDATA_I[7:0];
			end
			irq_q <= ctrl_d[ULSL_CTRL_THRIE_BIT] & (tx_cnt_d == 7'h00);
		end
	end

	// Receive pointers and occupancy
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			rx_cnt_q <= 7'h00;
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (store) begin
				wr_ptr_q <= wr_ptr_q + 6'h01;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 6'h01;
			end
			if (store & ~pop) begin
				rx_cnt_q <= rx_cnt_q + 7'h01;
			end else if (pop & ~store) begin
				rx_cnt_q <= rx_cnt_q - 7'h01;
			end
		end
	end

	// Per-character flag storage, one entry per queue slot
	generate
		for (genvar i = 0; i < 64; i++) begin : g_flag
			always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
				if (SYS_RST_I) begin
					flag_mem_q[i] <= ULSL_FLAGS_RESET;
				end else if (store & (wr_ptr_q == 6'(i))) begin
					flag_mem_q[i] <= pf;
				end
			end
		end
	endgenerate

	// Sticky flags; read clears only what the host saw, so set wins
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			err_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			err_q <= (err_q & ~(rd_clr & prdata_q[7])) | err_set;
			oe_q  <= (oe_q & ~(rd_clr & prdata_q[1])) | ovr_set;
		end
	end

	// Break arm: held until the line returns high
	always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			brk_arm_q <= 1'b0;
		end else begin
			brk_arm_q <= (brk_arm_q | brk_push) & ~RX_LINE_I;
		end
	end

	// ==========================================================
	// Output drive
	assign PRDATA_O  = prdata_q;
	assign PREADY_O  = pready_q;
	assign PSLVERR_O = slverr_q;
	assign TX_LOAD_O = load_q;
	assign TX_BYTE_O = byte_q;
	assign THR_IRQ_O = irq_q;

	// ==========================================================
	// Checks
	err_set_a : assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		err_set |=> err_q)
		else $error("error summary not set");

	err_clear_a : assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		rd_clr && prdata_q[7] && !err_set |=> !err_q)
		else $error("error summary not cleared by read");

	temt_busy_a : assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		(tx_cnt_q != 7'h00) || TX_SHIFT_BUSY_I |-> !line_status.temt)
		else $error("empty shown while data held");

	thre_xfer_a : assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		tx_cnt_q == 7'h01 && take && !accept |=> line_status.thre)
		else $error("holding empty not set on transfer");

	thre_write_a : assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		accept && !take |=> !line_status.thre && TX_LOAD_O)
		else $error("holding empty not cleared by write");

	irq_level_a : assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		THR_IRQ_O == (ctrl_q[ULSL_CTRL_THRIE_BIT] && line_status.thre))
		else $error("interrupt does not follow enable and empty");

	irq_drop_a : assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		$fell(line_status.thre) |-> !THR_IRQ_O)
		else $error("interrupt not withdrawn");

	brk_once_a : assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		brk_push && !RX_LINE_I |=> !brk_push)
		else $error("second break character queued");

	data_ready_a : assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		store |=> line_status.dr)
		else $error("data ready not set");

endmodule // ulsl_line_status

`default_nettype wire

// *** shared/ulsl_pkg.sv ***
// Package: register map, field layouts and queue sizes of the line status logic
package ulsl_pkg;

	// ==========================================================
	// Register map (byte addresses on the APB)
	localparam logic [11:0] ULSL_OFS_STATUS = 12'h000;
	localparam logic [11:0] ULSL_OFS_CTRL   = 12'h004;
	localparam logic [11:0] ULSL_OFS_TXDATA = 12'h008;

	// ==========================================================
	// Control register fields and reset value
	localparam int          ULSL_CTRL_FIFO_BIT = 0;
	localparam int          ULSL_CTRL_THRIE_BIT = 1;
	localparam logic [1:0]  ULSL_CTRL_RESET = 2'h0;

	// ==========================================================
	// Queue sizing
	localparam logic [6:0]  ULSL_DEPTH = 7'h40;
	localparam logic [6:0]  ULSL_SINGLE = 7'h01;
	localparam int          ULSL_PTR_W = 6;

	// ==========================================================
	// Per-character receive error flags
	typedef struct packed {
		logic bi;
		logic fe;
		logic pe;
	} ulsl_rxflags_type;

	localparam ulsl_rxflags_type ULSL_FLAGS_RESET = 3'h0;

	// Line status byte, bit 7 down to bit 0
	typedef struct packed {
		logic err;
		logic temt;
		logic thre;
		logic bi;
		logic fe;
		logic pe;
		logic oe;
		logic dr;
	} ulsl_lsr_type;

endpackage

// *** testbench/ulsl_engine_model.sv ***
// Transmit engine stand-in: takes held characters into a slow shift register
`timescale 1ns/1ps
`default_nettype none

module ulsl_engine_model (
	input  wire logic clk_i,   // System clock
	input  wire logic rst_i,   // Async reset
	input  wire logic stall_i, // Hold characters back
	input  wire logic load_i,  // Character accepted
	output logic      take_o,  // Character into shift register
	output logic      busy_o   // Shift register occupied
);
	logic [6:0] pend_q;
	logic [4:0] cnt_q;
	logic       go;

	// ==========================================================
	// One character per 21 cycles, so status can be read mid-shift
	assign go = !stall_i && pend_q != 7'h00 && cnt_q == 5'h00 && !take_o;
	assign busy_o = cnt_q != 5'h00;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_q <= 7'h00;
			cnt_q <= 5'h00;
			take_o <= 1'b0;
		end else begin
			pend_q <= pend_q + {6'h00, load_i} - {6'h00, go};
			take_o <= go;
			cnt_q <= go ? 5'h14 : (cnt_q != 5'h00 ? cnt_q - 5'h01 : cnt_q);
		end
	end
endmodule // ulsl_engine_model

`default_nettype wire

// *** testbench/ulsl_line_status_tb.sv ***
// Self-checking testbench of the line status logic
`timescale 1ns/1ps
`default_nettype none

module ulsl_line_status_tb;
	import ulsl_pkg::*;
	logic             clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, stall = 1;
	logic             rx_push = 0, rx_pop = 0, rx_low = 0, rx_line = 1, err_seen;
	logic [11:0]      paddr = 12'h000;
	logic [31:0]      pwdata = 32'h0000_0000, prdata, rd;
	logic             pready, pslverr, tx_load, tx_take, busy, irq;
	logic [7:0]       tx_byte;
	ulsl_rxflags_type rx_flags = ULSL_FLAGS_RESET;
	int               n_mismatch = 0, check_count = 0, cyc = 0;

	ulsl_line_status ulsl_line_status_inst (.CLOCK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .TX_LOAD_O(tx_load),
		.TX_BYTE_O(tx_byte), .TX_TAKE_I(tx_take), .TX_SHIFT_BUSY_I(busy),
		.RX_PUSH_I(rx_push), .RX_FLAGS_I(rx_flags), .RX_POP_I(rx_pop),
		.RX_FRAME_LOW_I(rx_low), .RX_LINE_I(rx_line), .THR_IRQ_O(irq));
	ulsl_engine_model ulsl_engine_model_inst (.clk_i(clk), .rst_i(rst), .stall_i(stall),
		.load_i(tx_load), .take_o(tx_take), .busy_o(busy));

	// ==========================================================
	// Clock, hang guard, verdict
	always #50 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim;
		end
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// ==========================================================
	// Bus and line helpers; slave latency is not assumed
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// No latency assumed; only the hang guard ends this wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err_seen = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask

	task automatic st(input logic [7:0] e);
		apb(0, ULSL_OFS_STATUS, 32'h0000_0000);
		chk("status", rd, {24'h00_0000, e});
	endtask

	task automatic rxp(input logic pu, po, lo, input ulsl_rxflags_type f);
		rx_push <= pu;
		rx_pop <= po;
		rx_low <= lo;
		rx_flags <= f;
		@(posedge clk);
		rx_push <= 0;
		rx_pop <= 0;
		rx_low <= 0;
		@(posedge clk);
	endtask

	// Engine waits end only through the hang guard, never silently
	task automatic wait_take;
		while (tx_take !== 1'b1) @(posedge clk);
	endtask

	task automatic wait_idle;
		while (busy !== 1'b0) @(posedge clk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		st(8'h60);
		chk("slverr", err_seen, 0);
		chk("pready", pready, 0);
	endtask

	task automatic t_unmapped;
		apb(0, 12'h00C, 32'h0000_0000);
		chk("slverr", err_seen, 1);
		chk("rdata", rd, 32'h0000_0000);
	endtask

	task automatic t_single;
		apb(1, ULSL_OFS_CTRL, 32'h0000_0002);
		chk("irq", irq, 1);
		apb(1, ULSL_OFS_TXDATA, 32'h0000_005A);
		chk("txbyte", tx_byte, 8'h5A);
		chk("txload", tx_load, 1);
		st(8'h00);
		chk("irq", irq, 0);
		// Holding register full: a second character is dropped
		apb(1, ULSL_OFS_TXDATA, 32'h0000_00A5);
		chk("txload", tx_load, 0);
		chk("txbyte", tx_byte, 8'h5A);
		stall <= 0;
		wait_take;
		st(8'h20);
		wait_idle;
		st(8'h60);
		stall <= 1;
		apb(1, ULSL_OFS_CTRL, 32'h0000_0000);
		chk("irq", irq, 0);
	endtask

	task automatic t_queued;
		apb(1, ULSL_OFS_CTRL, 32'h0000_0001);
		apb(0, ULSL_OFS_CTRL, 32'h0000_0000);
		chk("ctrl", rd, 32'h0000_0001);
		apb(1, ULSL_OFS_TXDATA, 32'h0000_0011);
		apb(1, ULSL_OFS_TXDATA, 32'h0000_0022);
		st(8'h00);
		stall <= 0;
		wait_take;
		st(8'h00);
		@(posedge clk);
		wait_take;
		st(8'h20);
		wait_idle;
		st(8'h60);
		stall <= 1;
	endtask

	task automatic t_rx;
		rxp(1, 0, 0, 3'b010);
		st(8'hE9);
		st(8'h69);
		rxp(0, 1, 0, 3'b000);
		st(8'h60);
		rx_line <= 0;
		repeat (3) rxp(0, 0, 1, 3'b000);
		st(8'hF1);
		rxp(0, 1, 0, 3'b000);
		st(8'h60);
		rx_line <= 1;
		// Single mode: parity char held, next one overruns
		apb(1, ULSL_OFS_CTRL, 32'h0000_0000);
		rxp(1, 0, 0, 3'b001);
		rxp(1, 0, 0, 3'b000);
		st(8'hE7);
		st(8'h65);
		rxp(0, 1, 0, 3'b000);
		st(8'h60);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		t_reset;
		t_single;
		t_queued;
		t_rx;
		t_unmapped;
		end_sim;
	end
endmodule // ulsl_line_status_tb

`default_nettype wire
